// [bench/tach_period_counter_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tach_period_counter_tb;
   import tpc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, tach_in, sample_req, pready, pslverr, sample_valid, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, sample_data, rd, last, rdf, fix_prdata, fix_data;
   logic [15:0] period, high;
   int bad_count, num_checks, p, n;
   tpc_period_counter uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .tach_in, .sample_req, .sample_data, .sample_valid);
   tpc_tach_model tach (.pclk, .period, .high, .tach_in);
   // A copy with the configuration fixed shares the bus and the tachometer input.
   tpc_period_counter #(.FIXED_CONFIG(1'b1)) uut_fixed (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata(fix_prdata), .pready(), .pslverr(), .tach_in, .sample_req, .sample_data(fix_data),
      .sample_valid());
   always #10 pclk = ~pclk;
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      rdf = fix_prdata;
      err = pslverr;
      if (pready !== 1'b1) begin
         bad_count++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task results;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   initial begin
      repeat (60000) @(posedge pclk);
      bad_count++;
      results();
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, sample_req, paddr, pwdata} = '0;
      {period, high, last, bad_count, num_checks} = '0;
      void'($urandom(32'h731d));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, TPC_OFF_STATUS, TPC_ZERO);
      check("status", rd, TPC_ZERO);
      apb(1'b1, 8'h10, 32'hFFFF_FFFF);
      check("unmapped", {rd[30:0], err}, 32'h0000_0001);
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         p = 25 * (2 + $urandom % 20);
         period <= p[15:0];
         high <= 16'(1 + $urandom % 40);
         apb(1'b1, TPC_OFF_CTRL, 32'(c));
         apb(1'b1, TPC_OFF_START, 32'h0000_0008);
         apb(1'b0, TPC_OFF_RESULT, TPC_ZERO);
         check("early", rd, {c[2], c[1] ? last[30:0] : 31'h0});
         check("fixed early", rdf, last);
         n = 0;
         do begin
            apb(1'b0, TPC_OFF_STATUS, TPC_ZERO);
            n++;
         end while (rd[TPC_STAT_DONE_BIT] !== 1'b1 && n < 1000);
         // Waiting a full period more shows the finished counter does not rearm by itself.
         repeat (p) @(posedge pclk);
         apb(1'b0, TPC_OFF_STATUS, TPC_ZERO);
         check("held", rd[1:0], 32'h0000_0002);
         last = 32'(p * 6 / 25);
         @(posedge pclk);
         sample_req <= 1'b1;
         @(posedge pclk);
         sample_req <= 1'b0;
         @(posedge pclk);
         check("valid", sample_valid, 1'b1);
         check("result", sample_data, last);
         check("fixed result", fix_data, last);
         apb(1'b0, TPC_OFF_RESULT, TPC_ZERO);
         check("rearmed", rd, {c[2], c[1] ? last[30:0] : 31'h0});
         check("fixed rearmed", rdf, last);
         apb(1'b0, TPC_OFF_STATUS, TPC_ZERO);
         check("rearm status", rd[2:1], 32'h0000_0002);
         apb(1'b1, TPC_OFF_START, TPC_ZERO);
         $display("test config %0d done", c);
      end
      results();
   end
endmodule : tach_period_counter_tb
bind tpc_period_counter tpc_period_counter_props props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .tach_in, .sample_req, .sample_data, .sample_valid);
`default_nettype wire

// [bench/tpc_period_counter_props.sv]
`timescale 1ns/1ps
`default_nettype none
module tpc_period_counter_props
   import tpc_pkg::*;
(
   // APB side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Tachometer and sequencer side
   input wire logic tach_in,
   input wire logic sample_req,
   input wire logic [31:0] sample_data,
   input wire logic sample_valid
);
   logic stale_q;
   logic mapped;
   assign mapped = paddr inside {TPC_OFF_CTRL, TPC_OFF_START, TPC_OFF_RESULT, TPC_OFF_STATUS};
   // The stale choice is only visible through the control writes, so it is shadowed here.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stale_q <= 1'b0;
      end else if (psel && penable && pready && pwrite && paddr == TPC_OFF_CTRL) begin
         stale_q <= pwdata[TPC_CTRL_STALE_BIT];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_answer; sample_req ##1 sample_valid; endsequence
   property p_ready; s_setup |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready missing after setup");
   property p_idle; !(psel && !penable) |=> !pready; endproperty
   a_idle: assert property (p_idle) else $error("pready without setup");
   property p_err; pready |-> pslverr == !mapped; endproperty
   a_err: assert property (p_err) else $error("pslverr wrong for address");
   property p_err_zero; pready && pslverr |-> prdata == TPC_ZERO; endproperty
   a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
   property p_answer; sample_req |-> s_answer; endproperty
   a_answer: assert property (p_answer) else $error("sample_valid missing");
   property p_one; !sample_req |=> !sample_valid; endproperty
   a_one: assert property (p_one) else $error("sample_valid without request");
   property p_msb; sample_valid && !stale_q |-> !sample_data[31]; endproperty
   a_msb: assert property (p_msb) else $error("sample top bit set with stale off");
   property p_msb_bus; pready && !pwrite && paddr == TPC_OFF_RESULT && !stale_q |-> !prdata[31]; endproperty
   a_msb_bus: assert property (p_msb_bus) else $error("result top bit set with stale off");
endmodule : tpc_period_counter_props
`default_nettype wire

// [bench/tpc_tach_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Edges land on pclk so every period is an exact number of cycles.
module tpc_tach_model (
   // Clock
   input wire logic pclk,
   // Waveform shape in pclk cycles
   input wire logic [15:0] period,
   input wire logic [15:0] high,
   // Conditioned level
   output logic tach_in
);
   logic [15:0] cnt = 16'h0000;
   initial tach_in = 1'b0;
   always @(posedge pclk) begin
      cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
      tach_in <= cnt < high;
   end
endmodule : tpc_tach_model
`default_nettype wire

// [inc/tpc_pkg.sv]
package tpc_pkg;
   // Register byte offsets on the APB window.
   localparam logic [7:0] TPC_OFF_CTRL = 8'h00;
   localparam logic [7:0] TPC_OFF_START = 8'h04;
   localparam logic [7:0] TPC_OFF_RESULT = 8'h08;
   localparam logic [7:0] TPC_OFF_STATUS = 8'h0C;
   // Control register fields.
   localparam int TPC_CTRL_EDGE_BIT = 0;
   localparam int TPC_CTRL_HOLD_BIT = 1;
   localparam int TPC_CTRL_STALE_BIT = 2;
   localparam int TPC_CTRL_RUN_BIT = 3;
   localparam logic [3:0] TPC_CTRL_RESET = 4'h0;
   // Status register fields.
   localparam int TPC_STAT_BUSY_BIT = 0;
   localparam int TPC_STAT_DONE_BIT = 1;
   localparam int TPC_STAT_ARMED_BIT = 2;
   localparam int TPC_STAT_SAT_BIT = 3;
   // Counter timebase.
   localparam int TPC_TIMEBASE_HZ = 12_000_000;
   localparam int TPC_COUNT_W = 32;
   localparam logic [31:0] TPC_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {
      TPC_IDLE,
      TPC_ARM,
      TPC_COUNT,
      TPC_DONE
   } tpc_state_type;
endpackage : tpc_pkg

// [rtl/tpc_edge_detect.sv]
`timescale 1ns/1ps
`default_nettype none
module tpc_edge_detect (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Conditioned tachometer level and edge choice
   input wire logic level,
   input wire logic falling,
   // One-cycle pulse on the chosen edge
   output logic edge_pulse
);
   logic prev;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 1'b0;
      end else begin
         prev <= level;
      end
   end
   assign edge_pulse = falling ? (prev & ~level) : (~prev & level);
endmodule : tpc_edge_detect
`default_nettype wire

// [rtl/tpc_period_counter.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The counter advances once per tick of the 12 MHz timebase, so one count is about 83 ns.
// - The result is the number of timebase ticks between two consecutive chosen starting edges.
// - When configurable, software picks a rising or falling tachometer edge as the starting edge.
// - When configurable, software picks whether reads between measurements give zero or the last value.
// - The fixed variant always uses the rising edge, returns the previous value and keeps the top bit at 0.
// - With the stale option on, fresh data has top bit 0 and a read before completion has top bit 1.
// - With the stale option off, the top bit of every returned value is 0.
// - After start, counting begins on the first starting edge and stops on the next starting edge.
// - A finished measurement holds the counter idle, neither counting nor rearming, until it is read.
// - The read after completion returns the fresh value whatever the configuration, and starts the next measurement.
module tpc_period_counter
   import tpc_pkg::*;
#(
   parameter bit FIXED_CONFIG = 1'b0,
   parameter int CLK_HZ = 50_000_000
) (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Conditioned tachometer input
   input wire logic tach_in,
   // Sequencer sample strobe for the tachometer channel
   input wire logic sample_req,
   output logic [31:0] sample_data,
   output logic sample_valid
);
   // Timebase step, accumulated per pclk so that one count is one 12 MHz tick.
   localparam logic [31:0] TB_STEP = 32'(TPC_TIMEBASE_HZ);
   localparam logic [31:0] TB_MOD = 32'(CLK_HZ);
   localparam logic [TPC_COUNT_W-1:0] CNT_MAX = {TPC_COUNT_W{1'b1}};

   tpc_state_type state;
   tpc_state_type next_state;
   logic [3:0] ctrl;
   logic [31:0] tb_acc;
   logic [TPC_COUNT_W-1:0] count;
   logic [TPC_COUNT_W-1:0] result;
   logic saturated;
   logic start_edge;

   // Effective configuration; the fixed variant ignores software.
   wire cfg_falling = FIXED_CONFIG ? 1'b0 : ctrl[TPC_CTRL_EDGE_BIT];
   wire cfg_hold = FIXED_CONFIG ? 1'b1 : ctrl[TPC_CTRL_HOLD_BIT];
   wire cfg_stale = FIXED_CONFIG ? 1'b0 : ctrl[TPC_CTRL_STALE_BIT];

   tpc_edge_detect u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .level(tach_in),
      .falling(cfg_falling),
      .edge_pulse(start_edge)
   );

   // APB decode. Zero wait states: answer in the access phase.
   wire apb_access = psel & penable;
   wire apb_wr = apb_access & pwrite;
   wire apb_rd = apb_access & ~pwrite;
   wire hit_ctrl = (paddr == TPC_OFF_CTRL);
   wire hit_start = (paddr == TPC_OFF_START);
   wire hit_result = (paddr == TPC_OFF_RESULT);
   wire hit_status = (paddr == TPC_OFF_STATUS);
   wire hit_any = hit_ctrl | hit_start | hit_result | hit_status;
   wire wr_ctrl = apb_wr & hit_ctrl;
   wire wr_start = apb_wr & hit_start & pwdata[TPC_CTRL_RUN_BIT];
   wire wr_stop = apb_wr & hit_start & ~pwdata[TPC_CTRL_RUN_BIT];

   // Reads of the result come from software or from the sequencer slot.
   wire rd_result = (apb_rd & hit_result) | sample_req;
   wire done = (state == TPC_DONE);

   // Returned value: fresh data on completion, otherwise zero or last value.
   wire [TPC_COUNT_W-1:0] between_val = cfg_hold ? result : TPC_ZERO;
   wire [TPC_COUNT_W-1:0] base_val = done ? result : between_val;
   wire msb_val = cfg_stale & ~done;
   wire [31:0] read_val = {msb_val, base_val[TPC_COUNT_W-2:0]};

   // Timebase tick at 12 MHz average rate from the bus clock.
   wire [32:0] tb_sum = {1'b0, tb_acc} + {1'b0, TB_STEP};
   wire tb_tick = (tb_sum >= {1'b0, TB_MOD});
   wire [31:0] next_tb_acc = tb_tick ? 32'(tb_sum - {1'b0, TB_MOD}) : tb_sum[31:0];

   wire at_max = (count == CNT_MAX);
   wire [TPC_COUNT_W-1:0] next_count_inc = at_max ? count : count + 1'b1;
   // The closing cycle's tick still belongs to the period, so it is folded into the result.
   wire [TPC_COUNT_W-1:0] count_final = tb_tick ? next_count_inc : count;

   always_comb begin
      next_state = state;
      case (state)
         TPC_IDLE: begin
            if (wr_start) begin
               next_state = TPC_ARM;
            end
         end
         TPC_ARM: begin
            if (start_edge) begin
               next_state = TPC_COUNT;
            end
         end
         TPC_COUNT: begin
            if (start_edge) begin
               next_state = TPC_DONE;
            end
         end
         TPC_DONE: begin
            if (rd_result) begin
               next_state = TPC_ARM;
            end
         end
         default: begin
            next_state = TPC_IDLE;
         end
      endcase
      if (wr_stop) begin
         next_state = TPC_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= TPC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= TPC_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tb_acc <= TPC_ZERO;
      end else begin
         tb_acc <= next_tb_acc;
      end
   end

   // Counter clears on the opening edge and counts ticks until the closing one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= TPC_ZERO;
      end else if (state == TPC_ARM && start_edge) begin
         count <= TPC_ZERO;
      end else if (state == TPC_COUNT && tb_tick && !start_edge) begin
         count <= next_count_inc;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= TPC_ZERO;
         saturated <= 1'b0;
      end else if (state == TPC_COUNT && start_edge) begin
         result <= count_final;
         saturated <= (count_final == CNT_MAX);
      end
   end

   wire [31:0] status_val = {28'h000_0000, saturated, (state != TPC_IDLE),
                             done, (state == TPC_COUNT)};
   wire [31:0] ctrl_val = {28'h000_0000, ctrl};
   wire [31:0] start_val = {28'h000_0000, (state != TPC_IDLE), 3'b000};
   wire [31:0] next_prdata = hit_ctrl ? ctrl_val :
                             hit_start ? start_val :
                             hit_result ? read_val :
                             hit_status ? status_val : TPC_ZERO;

   // Bus outputs are registered; pready rises in the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= TPC_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_any;
      end
   end

   // Sequencer slot: value appears the cycle after the strobe.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_data <= TPC_ZERO;
         sample_valid <= 1'b0;
      end else begin
         sample_valid <= sample_req;
         if (sample_req) begin
            sample_data <= read_val;
         end
      end
   end
endmodule : tpc_period_counter
`default_nettype wire
